// ===== hdl/anc_audio_parser.sv
`timescale 1ns/10ps
// Parses one 10-bit ancillary stream for HD-style or SD-style audio packets
module anc_audio_parser #(
  parameter int CH_BASE = 0
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Word input
  input wire logic word_valid,
  input wire logic [9:0] word,
  input wire logic sd_style,
  input wire logic [7:0] did_base,
  // Parsed sample out
  output logic smp_valid,
  output audio_extract_pkg::audio_beat_t smp,
  output logic ctrl_seen,
  output logic [2:0] rate_code
);

  // Base plus sixteen group channels must still fit the 5-bit channel field
  if (CH_BASE < 0 || CH_BASE > 16) begin : g_bad_base
    $error("anc_audio_parser: CH_BASE out of range");
  end

  typedef enum logic [3:0] {
    S_IDLE, S_F1, S_F2, S_DID, S_SDID, S_DC, S_PAY, S_CS
  } pstate_t;

  typedef struct packed {
    pstate_t st;
    logic is_data;
    logic is_ctrl;
    logic [7:0] left;
    logic [3:0] idx;
    logic [1:0] grp;
    logic [23:0] acc;
    logic [1:0] sub;
    logic [1:0] ch;
    logic first;
    logic out_v;
    audio_extract_pkg::audio_beat_t out;
    logic ctrl_q;
    logic [2:0] rate;
  } pstate_all_t;

  pstate_all_t s_q, s_d;

  // Group number of a packet id, zero when not one of ours
  function automatic logic [2:0] grp_of(input logic [7:0] id,
                                        input logic [7:0] base,
                                        input logic sd);
    logic [7:0] diff;
    diff = base - id;
    if (sd) begin
      grp_of = (diff[0] == 1'b0 && diff < 8'h08) ?
        {1'b0, diff[2:1]} + 3'h1 : 3'h0;
    end else begin
      grp_of = (diff < 8'h04) ? diff[2:0] + 3'h1 : 3'h0;
    end
  endfunction

  // Build an AES3 subframe around a 24-bit sample
  function automatic logic [31:0] aes_pack(input logic [23:0] smpl,
                                           input logic frst,
                                           input logic rgt);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[audio_extract_pkg::AES_SAMPLE_LSB +: 24] = smpl;
    w[audio_extract_pkg::AES_PREAMBLE_LSB +: 4] = frst ?
      audio_extract_pkg::PRE_Z :
      (rgt ? audio_extract_pkg::PRE_Y : audio_extract_pkg::PRE_X);
    w[audio_extract_pkg::AES_P_BIT] = ^w[30:4];
    aes_pack = w;
  endfunction

  // Packet walk: flags, DID, SDID/DBN, DC, payload, checksum
  always_comb begin
    logic [2:0] g;
    g = grp_of(word[7:0], did_base, sd_style);
    s_d = s_q;
    s_d.out_v = 1'b0;
    s_d.ctrl_q = 1'b0;
    if (word_valid) begin
      unique case (s_q.st)
        S_IDLE: s_d.st = (word == audio_extract_pkg::ADF0) ? S_F1 : S_IDLE;
        S_F1: s_d.st = (word == audio_extract_pkg::ADF1) ? S_F2 : S_IDLE;
        S_F2: s_d.st = (word == audio_extract_pkg::ADF1) ? S_DID : S_IDLE;
        S_DID: begin
          s_d.is_data = (g != 3'h0);
          s_d.is_ctrl = (word[7:0] == audio_extract_pkg::DID_CTRL_G1);
          s_d.grp = g[1:0] - 2'h1;
          s_d.st = (g != 3'h0 || s_d.is_ctrl) ? S_SDID : S_IDLE;
        end
        S_SDID: s_d.st = S_DC;
        S_DC: begin
          s_d.left = word[7:0];
          s_d.idx = 4'h0;
          s_d.sub = 2'h0;
          s_d.ch = 2'h0;
          s_d.st = (word[7:0] == 8'h00) ? S_CS : S_PAY;
        end
        S_PAY: begin
          s_d.idx = s_q.idx + 4'h1;
          s_d.left = s_q.left - 8'h01;
          if (s_q.is_ctrl && s_q.idx == 4'h1) begin
            s_d.rate = word[2:0];
          end
          if (s_q.is_data) begin
            // SD packs 24 bits in three words, HD 24 bits in four
            unique case (s_q.sub)
              2'h0: s_d.acc = {word[7:0], 16'h0000};
              2'h1: s_d.acc = {s_q.acc[23:16], word[7:0], 8'h00};
              2'h2: s_d.acc = {s_q.acc[23:8], word[7:0]};
              default: s_d.acc = s_q.acc;
            endcase
            s_d.sub = (s_q.sub == (sd_style ? 2'h2 : 2'h3)) ? 2'h0 :
              s_q.sub + 2'h1;
            if (s_q.sub == (sd_style ? 2'h2 : 2'h3)) begin
              s_d.out_v = 1'b1;
              s_d.out.chan = 5'(CH_BASE) + {1'b0, s_q.grp, s_q.ch};
              s_d.out.data = aes_pack(s_d.acc, s_q.first && s_q.ch == 2'h0,
                                      s_q.ch[0]);
              s_d.ch = s_q.ch + 2'h1;
              if (s_q.ch == 2'h3) begin
                s_d.first = 1'b0;
              end
            end
          end
          if (s_q.left == 8'h01) begin
            s_d.st = S_CS;
          end
        end
        S_CS: begin
          s_d.ctrl_q = s_q.is_ctrl;
          s_d.st = S_IDLE;
        end
        default: s_d.st = S_IDLE;
      endcase
    end
    if (!rst_n) begin
      s_d = '0;
      s_d.st = S_IDLE;
      s_d.first = 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    s_q <= s_d;
  end

  assign smp_valid = s_q.out_v;
  assign smp = s_q.out;
  assign ctrl_seen = s_q.ctrl_q;
  assign rate_code = s_q.rate;

endmodule

// ===== hdl/audio_extract_pkg.sv
package audio_extract_pkg;

  // Receiver line modes
  typedef enum logic [2:0] {
    MODE_HD = 3'h0,
    MODE_SD = 3'h1,
    MODE_3G = 3'h2,
    MODE_6G = 3'h4,
    MODE_12G = 3'h5
  } line_mode_t;

  // Ancillary framing and packet identifiers
  localparam logic [9:0] ADF0 = 10'h000;
  localparam logic [9:0] ADF1 = 10'h3ff;
  localparam logic [7:0] DID_CTRL_G1 = 8'he3;
  localparam logic [7:0] DID_DATA_G1 = 8'he7;
  localparam logic [7:0] DID_SD_G1 = 8'hff;
  localparam logic [7:0] DID_SD_STEP = 8'h02;
  localparam logic [7:0] DID_HD_STEP = 8'h01;
  localparam int unsigned GROUPS = 8;
  localparam int unsigned CH_PER_GROUP = 4;
  localparam int unsigned MAX_CHANNELS = 32;
  localparam int unsigned SD_MAX_CHANNELS = 16;
  localparam int unsigned HD_MAX_CHANNELS = 16;
  localparam int unsigned STREAMS = 4;

  // Audio sample rates (Hz), as carried in control packets
  localparam int unsigned RATE_32K = 32000;
  localparam int unsigned RATE_44K1 = 44100;
  localparam int unsigned RATE_48K = 48000;
  localparam logic [2:0] RATE_CODE_48K = 3'h0;
  localparam logic [2:0] RATE_CODE_44K1 = 3'h1;
  localparam logic [2:0] RATE_CODE_32K = 3'h2;

  // SD sample enable cadence
  localparam int unsigned SD_CADENCE_SHORT = 5;
  localparam int unsigned SD_CADENCE_LONG = 6;

  // AES3 subframe field positions
  localparam int unsigned AES_PREAMBLE_LSB = 0;
  localparam int unsigned AES_AUX_LSB = 4;
  localparam int unsigned AES_SAMPLE_LSB = 4;
  localparam int unsigned AES_V_BIT = 28;
  localparam int unsigned AES_U_BIT = 29;
  localparam int unsigned AES_C_BIT = 30;
  localparam int unsigned AES_P_BIT = 31;
  localparam logic [3:0] PRE_Z = 4'h1;
  localparam logic [3:0] PRE_X = 4'h2;
  localparam logic [3:0] PRE_Y = 4'h3;

  // Receiver data streams, one 10-bit word per stream
  typedef struct packed {
    logic [9:0] ds4;
    logic [9:0] ds3;
    logic [9:0] ds2;
    logic [9:0] ds1;
  } rx_streams_t;

  // One outgoing audio beat
  typedef struct packed {
    logic [31:0] data;
    logic [4:0] chan;
  } audio_beat_t;

endpackage

// ===== hdl/sdi_audio_extract.sv
`timescale 1ns/10ps
// Behaviour
// - Up to 32 channels in 16 pairs are recovered, synchronous or not.
// - Sample rates of 32, 44.1 and 48 kHz are tracked from control data.
// - In SD mode at most 16 channels are taken, from stream one only.
// - In HD mode at most 16 channels are taken from streams one and two.
// - In 3G, 6G and 12G mode up to 32 channels come from streams two and four.
// - Multi-stream control packets sit on streams 1/3, data on 2/4.
// - Input is the data streams plus mode and status; mode picks streams.
// - Audio leaves on a 32-bit AXI4-Stream master.
// - Each transfer carries one AES3 subframe with a 24-bit sample.
// - TID carries the channel number of each sample.
// - In SD mode a sample enable marks words at 27 MHz in 5-6-5-6 beats.
// - The receiver reset is active high and synchronous.
module sdi_audio_extract (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Receiver side
  input wire audio_extract_pkg::rx_streams_t rx_ds,
  input wire logic [2:0] rx_mode,
  input wire logic rx_mode_locked,
  input wire logic rx_core_rst,
  input wire logic sd_sample_enable,
  // Audio stream out
  output logic [31:0] m_axis_tdata,
  output logic [4:0] m_axis_tid,
  output logic m_axis_tvalid,
  input wire logic m_axis_tready,
  // Status
  output logic [2:0] rate_code,
  output logic audio_present
);

  typedef struct packed {
    logic [3:0] pend;
    audio_extract_pkg::audio_beat_t [3:0] hold;
    logic [1:0] rr;
    logic out_v;
    audio_extract_pkg::audio_beat_t out;
    logic [2:0] rate;
    logic present;
  } top_state_t;

  top_state_t s_q, s_d;
  logic word_v;
  logic sd_mode;
  logic hd_mode;
  logic multi;
  logic core_rst_n;
  logic [3:0] pv;
  audio_extract_pkg::audio_beat_t [3:0] pb;
  logic [3:0] pc;
  logic [2:0] rc [4];
  logic [3:0] en;
  logic [9:0] wd [4];

  // Decode of receiver mode; unlocked receiver takes nothing
  assign sd_mode = rx_mode == audio_extract_pkg::MODE_SD;
  assign hd_mode = rx_mode == audio_extract_pkg::MODE_HD;
  assign multi = !sd_mode && !hd_mode;
  // Receiver reset is active high; either reset clears the parsers
  assign core_rst_n = rst_n && !rx_core_rst;
  // In SD only strobed words count; the cadence is the receiver's job
  assign word_v = sd_mode ? sd_sample_enable : 1'b1;

  // Stream enables per mode
  always_comb begin
    en = 4'h0;
    if (rx_mode_locked) begin
      if (sd_mode) begin
        en = 4'h1;
      end else if (hd_mode) begin
        en = 4'h3;
      end else begin
        en = 4'hf;
      end
    end
  end

  assign wd[0] = rx_ds.ds1;
  assign wd[1] = rx_ds.ds2;
  assign wd[2] = rx_ds.ds3;
  assign wd[3] = rx_ds.ds4;

  // One parser per stream; channel bases split 16 pairs over streams
  for (genvar i = 0; i < 4; i++) begin : g_parse
    localparam logic [7:0] BASE_HD = (i < 2) ?
      audio_extract_pkg::DID_DATA_G1 : audio_extract_pkg::DID_DATA_G1 - 8'h04;
    anc_audio_parser #(
      .CH_BASE((i >= 2) ? 16 : 0)
    ) u_parse (
      .core_clk(core_clk),
      .rst_n(core_rst_n),
      .word_valid(word_v && en[i]),
      .word(wd[i]),
      .sd_style(sd_mode),
      .did_base(sd_mode ? audio_extract_pkg::DID_SD_G1 : BASE_HD),
      .smp_valid(pv[i]),
      .smp(pb[i]),
      .ctrl_seen(pc[i]),
      .rate_code(rc[i])
    );
  end

  // Collect samples: in multi modes only streams two/four carry data,
  // one/three carry control; HD and SD take data from every enabled parser.
  // A one-deep hold per stream keeps words while the sink stalls; a
  // sample that hits a full hold is dropped unless that hold drains in the same clock, since audio cannot pause.
  always_comb begin
    logic [3:0] take;
    logic found;
    logic [1:0] pick;
    take = multi ? (pv & 4'ha) : pv;
    found = 1'b0;
    pick = 2'h0;
    s_d = s_q;
    for (int k = 0; k < 4; k++) begin
      if (take[k] && !s_q.pend[k]) begin
        s_d.pend[k] = 1'b1;
        s_d.hold[k] = pb[k];
      end
    end
    if (!s_q.out_v || m_axis_tready) begin
      s_d.out_v = 1'b0;
      for (int k = 0; k < 4; k++) begin
        if (!found && s_q.pend[2'(s_q.rr + 2'(k))]) begin
          found = 1'b1;
          pick = 2'(s_q.rr + 2'(k));
        end
      end
      if (found) begin
        s_d.out_v = 1'b1;
        s_d.out = s_q.hold[pick];
        s_d.pend[pick] = take[pick];
        if (take[pick]) begin
          s_d.hold[pick] = pb[pick];
        end
        s_d.rr = pick + 2'h1;
      end
    end
    // Rate code from the control stream of the mode
    if (pc[0]) begin
      s_d.rate = rc[0];
      s_d.present = 1'b1;
    end else if (pc[2] && multi) begin
      s_d.rate = rc[2];
      s_d.present = 1'b1;
    end
    if (!rx_mode_locked) begin
      s_d.present = 1'b0;
    end
    if (!core_rst_n) begin
      s_d = '0;
    end
  end

  always_ff @(posedge core_clk) begin
    s_q <= s_d;
  end

  // Outputs straight from flip-flops; the port is 32 bits wide
  assign m_axis_tdata = s_q.out.data;
  assign m_axis_tid = s_q.out.chan;
  assign m_axis_tvalid = s_q.out_v;
  assign rate_code = s_q.rate;
  assign audio_present = s_q.present;

endmodule

// ===== verif/audio_extract_checker.sv
`timescale 1ns/10ps
// Port checks of the audio extractor
module audio_extract_checker (
  // Clock and resets
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic rx_core_rst,
  // Receiver side
  input wire audio_extract_pkg::rx_streams_t rx_ds,
  input wire logic [2:0] rx_mode,
  input wire logic rx_mode_locked,
  // Audio out
  input wire logic [31:0] m_axis_tdata,
  input wire logic [4:0] m_axis_tid,
  input wire logic m_axis_tvalid,
  input wire logic m_axis_tready,
  input wire logic [2:0] rate_code,
  input wire logic audio_present
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n || rx_core_rst);
  // Latency figures are checked only in HD, where a word arrives every clock
  wire logic hd = rx_mode_locked && rx_mode == 3'h0;
  wire logic [3:0] pre = m_axis_tdata[3:0];

  // Flag words, then the identifier, on one stream
  sequence hdr(logic [9:0] s, logic [7:0] id);
    s == 10'h000 ##1 s == 10'h3ff [*2] ##1 s[7:0] == id;
  endsequence

  a_reset_clears: assert property (disable iff (1'b0)
    !rst_n || rx_core_rst |=> !m_axis_tvalid && !audio_present
    && rate_code == 3'h0) else $error("outputs not cleared by reset");
  a_stall_hold: assert property (
    m_axis_tvalid && !m_axis_tready |=> m_axis_tvalid
    && $stable(m_axis_tdata) && $stable(m_axis_tid))
    else $error("beat changed while stalled");
  a_even_parity: assert property (
    m_axis_tvalid |-> ^m_axis_tdata[31:4] == 1'b0)
    else $error("subframe parity odd");
  a_status_bits: assert property (
    m_axis_tvalid |-> m_axis_tdata[30:28] == 3'h0)
    else $error("validity, user or status bit set");
  a_pair_preamble: assert property (
    m_axis_tvalid |-> (m_axis_tid[0] ? pre == 4'h3 : pre inside {4'h1, 4'h2}))
    else $error("preamble does not match channel");
  a_narrow_tid: assert property (
    m_axis_tvalid && rx_mode inside {3'h0, 3'h1} |-> !m_axis_tid[4])
    else $error("channel above 15 in SD or HD");
  a_unlocked_idle: assert property (
    (!rx_mode_locked) [*8] ##0 !m_axis_tvalid |=> !m_axis_tvalid)
    else $error("beat emerged while unlocked");
  a_data_latency: assert property (
    hdr(rx_ds.ds2, 8'he7) ##0 hd |-> ##[6:12] m_axis_tvalid)
    else $error("no beat after data packet");
  a_ctrl_present: assert property (
    hdr(rx_ds.ds1, 8'he3) ##0 hd |-> ##[3:30] audio_present)
    else $error("control packet not seen");
endmodule

bind sdi_audio_extract audio_extract_checker chk_u (
  .core_clk, .rst_n, .rx_core_rst, .rx_ds, .rx_mode, .rx_mode_locked,
  .m_axis_tdata, .m_axis_tid, .m_axis_tvalid, .m_axis_tready,
  .rate_code, .audio_present);

// ===== verif/rx_partner_model.sv
`timescale 1ns/10ps
// Receiver core and audio sink as seen by the extractor
module rx_partner_model (
  // Clock
  input wire logic core_clk,
  // Bench controls
  input wire logic sd_mode,
  input wire logic stall,
  // Toward the extractor
  output audio_extract_pkg::rx_streams_t rx_ds,
  output logic sd_sample_enable,
  output logic m_axis_tready
);
  logic [9:0] w [4] = '{10'h200, 10'h200, 10'h200, 10'h200};
  logic [2:0] cnt_q = 3'h0;
  logic long_q = 1'b0;
  assign rx_ds = {w[3], w[2], w[1], w[0]};
  assign m_axis_tready = !stall;

  // Gaps alternate five and six clocks, 27 MHz out of 148.5 MHz
  always @(negedge core_clk) begin
    if (cnt_q == 3'h0) begin
      sd_sample_enable <= sd_mode;
      cnt_q <= long_q ? 3'h5 : 3'h4;
      long_q <= !long_q;
    end else begin
      sd_sample_enable <= 1'b0;
      cnt_q <= cnt_q - 3'h1;
    end
  end

  function automatic logic [9:0] anc(input logic [7:0] b);
    return {~^b, ^b, b};
  endfunction

  // In SD a word stands until a strobe has taken it
  task automatic put(input int s, input logic [9:0] v);
    @(negedge core_clk);
    w[s] = v;
    do @(posedge core_clk); while (sd_mode && !sd_sample_enable);
  endtask

  // Flags, identifier, block, count, n equal bytes, checksum, idle
  task automatic send_pkt(input int s, input logic [7:0] id,
                          input logic [7:0] b, input int n);
    logic [8:0] sum;
    logic [9:0] hw [6];
    logic [9:0] pw;
    hw = '{10'h000, 10'h3ff, 10'h3ff, anc(id), anc(8'h01), anc(8'(n))};
    pw = anc(b);
    sum = 9'h000;
    foreach (hw[i]) begin
      put(s, hw[i]);
      if (i > 2) sum += hw[i][8:0];
    end
    repeat (n) begin
      put(s, pw);
      sum += pw[8:0];
    end
    put(s, {~sum[8], sum});
    put(s, 10'h200);
  endtask
endmodule

// ===== verif/tb_top.sv
`timescale 1ns/10ps
// Self-checking bench for the audio extractor
module tb_top;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic rx_core_rst = 1'b0;
  logic rx_mode_locked = 1'b0;
  logic [2:0] rx_mode = 3'h0;
  logic sd_mode = 1'b0;
  logic stall = 1'b1;
  audio_extract_pkg::rx_streams_t rx_ds;
  logic sd_sample_enable, m_axis_tready, m_axis_tvalid, audio_present;
  logic [31:0] m_axis_tdata;
  logic [4:0] m_axis_tid;
  logic [2:0] rate_code;
  int error_cnt = 0;
  int num_checks = 0;
  int cyc = 0;

  initial forever #5 core_clk = !core_clk;

  rx_partner_model src_u (.core_clk, .sd_mode, .stall, .rx_ds,
    .sd_sample_enable, .m_axis_tready);
  sdi_audio_extract dut_u (.core_clk, .rst_n, .rx_ds, .rx_mode,
    .rx_mode_locked, .rx_core_rst, .sd_sample_enable, .m_axis_tdata,
    .m_axis_tid, .m_axis_tvalid, .m_axis_tready, .rate_code,
    .audio_present);

  task automatic end_sim;
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Ceiling far above the several hundred clocks the tests need
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      end_sim();
    end
  end

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Sink stalls by default, so a beat cannot slip past unseen
  task automatic get_beat(input logic [4:0] id, input logic [23:0] smp,
                          input bit cmp);
    int n;
    logic [31:0] d;
    n = 0;
    // Look off the clock edge so a freshly launched beat has settled
    do begin
      @(negedge core_clk);
      n++;
    end while (m_axis_tvalid !== 1'b1 && n < 60);
    chk("valid", 32'h1, {31'h0, m_axis_tvalid});
    chk("tid", {27'h0, id}, {27'h0, m_axis_tid});
    if (cmp) chk("sample", {8'h0, smp}, {8'h0, m_axis_tdata[27:4]});
    d = m_axis_tdata;
    repeat (3) @(negedge core_clk);
    chk("held beat", d, m_axis_tdata);
    stall = 1'b0;
    @(negedge core_clk);
    stall = 1'b1;
    chk("taken", 32'h0, {31'h0, m_axis_tvalid});
  endtask

  task automatic no_beat(input int n);
    int seen;
    seen = 0;
    repeat (n) begin
      @(negedge core_clk);
      if (m_axis_tvalid !== 1'b0) seen++;
    end
    chk("stray beats", 32'h0, 32'(seen));
  endtask

  // HD: every rate code, then group one and group four under a stall
  task automatic t_hd;
    logic [2:0] rc [3];
    rc = '{3'h1, 3'h0, 3'h2};
    foreach (rc[i]) begin
      src_u.send_pkt(0, 8'he3, {5'h0, rc[i]}, 4);
      repeat (8) @(negedge core_clk);
      chk("present", 32'h1, {31'h0, audio_present});
      chk("rate", {29'h0, rc[i]}, {29'h0, rate_code});
    end
    src_u.send_pkt(1, 8'he7, 8'h5a, 4);
    get_beat(5'h0, 24'h5a5a5a, 1'b1);
    src_u.send_pkt(1, 8'he4, 8'ha5, 4);
    get_beat(5'hc, 24'ha5a5a5, 1'b1);
    $display("test hd finished");
  endtask

  // One-clock receiver reset in mid-run clears presence and rate
  task automatic t_core_rst;
    @(negedge core_clk);
    rx_core_rst = 1'b1;
    @(negedge core_clk);
    rx_core_rst = 1'b0;
    chk("after rst", 32'h0, {28'h0, rate_code, audio_present});
    $display("test core reset finished");
  endtask

  // Multi-stream modes: data from streams two and four, none from one
  task automatic t_multi;
    logic [2:0] md [3];
    md = '{3'h2, 3'h4, 3'h5};
    foreach (md[i]) begin
      @(negedge core_clk);
      rx_mode = md[i];
      src_u.send_pkt(2, 8'he3, 8'h02, 4);
      src_u.send_pkt(3, 8'he3, 8'h33, 4);
      get_beat(5'h10, 24'h333333, 1'b1);
      chk("rate", 32'h2, {29'h0, rate_code});
      src_u.send_pkt(1, 8'he7, 8'h66, 4);
      get_beat(5'h0, 24'h666666, 1'b1);
      src_u.send_pkt(0, 8'he7, 8'h66, 4);
      no_beat(20);
    end
    $display("test multi finished");
  endtask

  // Lost lock: a valid HD data packet yields nothing
  task automatic t_lock;
    @(negedge core_clk);
    rx_mode = 3'h0;
    rx_mode_locked = 1'b0;
    src_u.send_pkt(1, 8'he7, 8'h5a, 4);
    no_beat(20);
    chk("present", 32'h0, {31'h0, audio_present});
    rx_mode_locked = 1'b1;
    $display("test lock finished");
  endtask

  // SD: strobed words, stream one only, groups one and four
  task automatic t_sd;
    @(negedge core_clk);
    rx_mode = 3'h1;
    sd_mode = 1'b1;
    src_u.send_pkt(0, 8'hff, 8'h5a, 3);
    get_beat(5'h0, 24'h5a5a5a, 1'b1);
    src_u.send_pkt(0, 8'hf9, 8'h5a, 3);
    get_beat(5'hc, 24'h5a5a5a, 1'b1);
    src_u.send_pkt(1, 8'hff, 8'h5a, 3);
    no_beat(80);
    $display("test sd finished");
  endtask

  initial begin
    repeat (12) @(negedge core_clk);
    rst_n = 1'b1;
    rx_mode_locked = 1'b1;
    chk("idle", 32'h0, {m_axis_tvalid, m_axis_tdata[26:0], rate_code,
        audio_present});
    t_hd();
    t_core_rst();
    t_multi();
    t_lock();
    t_sd();
    end_sim();
  end
endmodule
